// >>> verilog/flash_pkg.sv
// package: opcodes, status layout, geometry, one-hot state codes and busy times
// assumes a 100 MHz core clock; serial link pins are sampled, not clocked on
`default_nettype none

package flash_pkg;

  // instruction opcodes
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
  localparam logic [7:0] OP_STATUS_UPDATE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_TWO_BIT_FETCH = 8'h3B;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_SMALL_CLEAR_A = 8'hD7;
  localparam logic [7:0] OP_SMALL_CLEAR_B = 8'h20;
  localparam logic [7:0] OP_LARGE_CLEAR = 8'hD8;
  localparam logic [7:0] OP_PERMIT_SET = 8'h06;
  localparam logic [7:0] OP_PERMIT_CLEAR = 8'h04;

  // status byte field positions
  localparam int ST_IN_PROGRESS = 0;
  localparam int ST_PERMIT = 1;
  localparam int ST_PROTECT_LO = 2;
  localparam int ST_LOCK = 7;
  localparam logic [2:0] PROTECT_RESET = 3'h0;

  // geometry
  localparam int ADDR_BYTES = 3;
  localparam int DEFAULT_ADDR_BITS = 18;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 4096;
  localparam int DEFAULT_BLOCK_BYTES = 65536;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // data path buffer
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;

  // busy times
  localparam int CLK_FREQ_MHZ = 100;
  localparam int PROGRAM_TIME_MS = 2;
  localparam int ERASE_TIME_MS = 10;
  localparam int STATUS_TIME_MS = 10;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_FREQ_MHZ;
  localparam int STATUS_CYCLES = STATUS_TIME_MS * 1000 * CLK_FREQ_MHZ;

  typedef enum logic [5:0] {
    PH_OPCODE = 6'b00_0001,
    PH_ADDR = 6'b00_0010,
    PH_DUMMY = 6'b00_0100,
    PH_READ_OUT = 6'b00_1000,
    PH_WRITE_IN = 6'b01_0000,
    PH_IGNORE = 6'b10_0000
  } phase_type;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_DRAIN = 4'b0010,
    ENG_WORK = 4'b0100,
    ENG_HOLD = 4'b1000
  } engine_type;

endpackage

`default_nettype wire

// >>> verilog/serial_flash_core.sv
// serial flash command core: link front end, page buffer fifo, array and busy engine
// assumes serial clock at most a quarter of the core clock; pins are asynchronous
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic do_push;
  logic do_pop;

  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (do_push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// Behaviour
// - decode 05 status read, 01 status write, 03/0B/3B reads, 02 program, D7/20/D8 erase.
// - while busy, every opcode except status read is ignored.
// - in-progress flag is 1 during program, erase or status write, else 0.
// - status write loads the three protect-range bits and the lock bit.
// - normal read takes three address bytes, most significant first.
// - only the low address bits matching array size are used.
// - read data leaves most significant bit first; address steps after each byte.
// - reading past the top address wraps to zero.
// - chip select high ends a read and releases the outputs.
// - fast and dual reads need one dummy byte before data.
// - inputs sampled on rising serial clock, outputs launched on falling edge.
// - dual read sends upper bit on serial out, next on bidirectional line.
// - a page program into a protected range is ignored.
// - program and erase run only with the write-permit latch set.
// - write-permit latch clears when a program, erase or status write completes.
// - program takes address and 1 to 256 bytes, starts on chip select rise.
// - over 256 bytes wrap inside the page; the last 256 are kept.
// - page bytes not sent in a partial program stay unchanged.
// - program only clears bits; erase sets every affected bit to 1.
// - sector erase clears one aligned 4 KByte sector only.
// - block erase clears one aligned 32 or 64 KByte block.
// - erase starts only at chip select rise after opcode and full address.
module serial_flash_core
  import flash_pkg::*;
#(
  parameter int ADDR_BITS = DEFAULT_ADDR_BITS,
  parameter int BLOCK_BYTES = DEFAULT_BLOCK_BYTES,
  parameter int PROGRAM_WAIT = PROGRAM_CYCLES,
  parameter int ERASE_WAIT = ERASE_CYCLES,
  parameter int STATUS_WAIT = STATUS_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial link from the host
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic bidir_serial_line_in,
  output logic bidir_serial_line_out,
  output logic bidir_serial_line_oe_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  // status bits
  output logic operation_in_progress_flag,
  output logic write_permit_latch,
  output logic protect_range_bit_2,
  output logic protect_range_bit_1,
  output logic protect_range_bit_0,
  output logic status_lock_bit,
  output logic fifo_overrun
);
  localparam int MEM_BYTES = 1 << ADDR_BITS;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask;

  // synchronisers: first stage feeds only the second
  logic sck_s1, sck_s2, sck_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic din_s1, din_s2;

  phase_type phase;
  engine_type state;
  logic [2:0] bit_cnt;
  logic [1:0] addr_idx;
  logic [7:0] in_sh;
  logic [15:0] addr_sh;
  logic [7:0] opcode;
  logic [ADDR_BITS-1:0] cmd_addr;
  logic addr_done;
  logic got_data;
  logic [7:0] stat_data;
  logic [7:0] prog_idx;
  logic [ADDR_BITS-1:0] rd_addr;
  logic [7:0] out_sh;
  logic [2:0] out_cnt;
  logic [7:0] job_op;
  logic [ADDR_BITS-1:0] base;
  logic [ADDR_BITS-1:0] walk;
  logic [ADDR_BITS-1:0] walk_last;
  logic [31:0] timer;

  logic sck_rise, sck_fall, selected, frame_end, byte_done;
  logic [7:0] next_byte;
  logic [23:0] next_addr;
  logic addr_load, push, clear_mask, launch, job_done;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FIFO_WIDTH-1:0] fifo_out_data;
  logic [7:0] status_byte;
  logic [ADDR_BITS-1:0] wr_addr;

  function automatic logic is_erase(input logic [7:0] op);
    return op == OP_SMALL_CLEAR_A || op == OP_SMALL_CLEAR_B || op == OP_LARGE_CLEAR;
  endfunction

  function automatic logic is_array_read(input logic [7:0] op);
    return op == OP_READ || op == OP_FAST_READ || op == OP_TWO_BIT_FETCH;
  endfunction

  // protected area is the top 1/2^(7-bp) of the array; bp 0 protects nothing
  function automatic logic in_protected(input logic [ADDR_BITS-1:0] a, input logic [2:0] bp);
    logic [ADDR_BITS:0] size;
    logic [ADDR_BITS:0] region;
    size = (ADDR_BITS+1)'(MEM_BYTES);
    region = size >> (3'd7 - bp);
    return (bp != 3'd0) && ({1'b0, a} >= size - region);
  endfunction

  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;
  assign selected = ~cs_s2;
  assign frame_end = cs_s2 & ~cs_s3;
  assign byte_done = selected & sck_rise & (bit_cnt == 3'd7);
  assign next_byte = {in_sh[6:0], din_s2};
  assign next_addr = {addr_sh, next_byte};
  assign addr_load = byte_done & (phase == PH_ADDR) & (addr_idx == 2'(ADDR_BYTES - 1));
  assign push = byte_done & (phase == PH_WRITE_IN) & (opcode == OP_PAGE_WRITE);
  assign clear_mask = byte_done & (phase == PH_OPCODE) & (next_byte == OP_PAGE_WRITE)
    & ~operation_in_progress_flag;
  assign status_byte = {status_lock_bit, 2'b00, protect_range_bit_2, protect_range_bit_1,
    protect_range_bit_0, write_permit_latch, operation_in_progress_flag};
  assign job_done = (state == ENG_HOLD) & (timer == 32'h0000_0000);
  assign fifo_out_ready = (state != ENG_WORK);
  assign wr_addr = base + walk;

  // accepted write-type frame ends cleanly on a byte boundary
  always_comb begin
    launch = 1'b0;
    if (frame_end && state == ENG_IDLE && bit_cnt == 3'd0 && write_permit_latch) begin
      if (opcode == OP_PAGE_WRITE) begin
        launch = (phase == PH_WRITE_IN) && got_data
          && !in_protected(cmd_addr, {protect_range_bit_2, protect_range_bit_1,
          protect_range_bit_0});
      end else if (is_erase(opcode)) begin
        launch = addr_done && !in_protected(cmd_addr, {protect_range_bit_2,
          protect_range_bit_1, protect_range_bit_0});
      end else if (opcode == OP_STATUS_UPDATE) begin
        // the data byte moves the phase on, so only its arrival counts
        launch = got_data;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sck_s1 <= serial_clk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      din_s1 <= bidir_serial_line_in;
      din_s2 <= din_s1;
    end
  end

  // input side: opcode, address, dummy and data bytes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= PH_OPCODE;
      bit_cnt <= 3'd0;
      addr_idx <= 2'd0;
      in_sh <= 8'h00;
      addr_sh <= 16'h0000;
      opcode <= OP_NONE;
      cmd_addr <= '0;
      addr_done <= 1'b0;
      got_data <= 1'b0;
      stat_data <= 8'h00;
      prog_idx <= 8'h00;
    end else if (!selected) begin
      phase <= PH_OPCODE;
      bit_cnt <= 3'd0;
      addr_idx <= 2'd0;
      addr_done <= 1'b0;
      got_data <= 1'b0;
      if (!frame_end) begin
        opcode <= OP_NONE;
      end
    end else if (sck_rise) begin
      in_sh <= next_byte;
      bit_cnt <= bit_cnt + 3'd1;
      if (byte_done) begin
        case (phase)
          PH_OPCODE: begin
            if (operation_in_progress_flag && next_byte != OP_STATUS_FETCH) begin
              opcode <= OP_NONE;
              phase <= PH_IGNORE;
            end else begin
              opcode <= next_byte;
              if (next_byte == OP_STATUS_FETCH) begin
                phase <= PH_READ_OUT;
              end else if (is_array_read(next_byte) || is_erase(next_byte)
                  || next_byte == OP_PAGE_WRITE) begin
                phase <= PH_ADDR;
              end else if (next_byte == OP_STATUS_UPDATE) begin
                phase <= PH_WRITE_IN;
              end else begin
                phase <= PH_IGNORE;
              end
            end
          end
          PH_ADDR: begin
            addr_sh <= next_addr[15:0];
            addr_idx <= addr_idx + 2'd1;
            if (addr_load) begin
              cmd_addr <= next_addr[ADDR_BITS-1:0];
              prog_idx <= next_byte;
              addr_done <= 1'b1;
              if (opcode == OP_READ) begin
                phase <= PH_READ_OUT;
              end else if (opcode == OP_PAGE_WRITE) begin
                phase <= PH_WRITE_IN;
              end else if (is_array_read(opcode)) begin
                phase <= PH_DUMMY;
              end else begin
                phase <= PH_IGNORE;
              end
            end
          end
          PH_DUMMY: phase <= PH_READ_OUT;
          PH_WRITE_IN: begin
            got_data <= 1'b1;
            if (opcode == OP_PAGE_WRITE) begin
              prog_idx <= prog_idx + 8'd1;
            end else begin
              stat_data <= next_byte;
              phase <= PH_IGNORE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // output side: data launched on falling serial clock
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
      bidir_serial_line_out <= 1'b0;
      bidir_serial_line_oe_n <= 1'b1;
      rd_addr <= '0;
      out_sh <= 8'h00;
      out_cnt <= 3'd0;
    end else if (!selected) begin
      serial_out_oe_n <= 1'b1;
      bidir_serial_line_oe_n <= 1'b1;
      out_cnt <= 3'd0;
    end else if (addr_load) begin
      rd_addr <= next_addr[ADDR_BITS-1:0];
    end else if (sck_fall && phase == PH_READ_OUT) begin
      automatic logic [7:0] b = out_sh;
      if (out_cnt == 3'd0) begin
        if (opcode == OP_STATUS_FETCH) begin
          b = status_byte;
        end else begin
          b = mem[rd_addr];
          rd_addr <= rd_addr + 1'b1;
        end
      end
      serial_out <= b[7];
      serial_out_oe_n <= 1'b0;
      if (opcode == OP_TWO_BIT_FETCH) begin
        bidir_serial_line_out <= b[6];
        bidir_serial_line_oe_n <= 1'b0;
        out_sh <= {b[5:0], 2'b00};
        out_cnt <= out_cnt + 3'd2;
      end else begin
        out_sh <= {b[6:0], 1'b0};
        out_cnt <= out_cnt + 3'd1;
      end
    end
  end

  // program bytes travel tagged with their in-page index
  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_data({prog_idx, next_byte}),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_overrun <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      fifo_overrun <= 1'b1;
    end else if (clear_mask) begin
      fifo_overrun <= 1'b0;
    end
  end

  // later bytes at the same index overwrite earlier ones
  always_ff @(posedge clock) begin
    if (fifo_out_valid && fifo_out_ready) begin
      page_buf[fifo_out_data[15:8]] <= fifo_out_data[7:0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      page_mask <= '0;
    end else if (clear_mask) begin
      page_mask <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      page_mask[fifo_out_data[15:8]] <= 1'b1;
    end
  end

  // busy engine: drain buffer (program only), walk the region, then hold until the busy time counted from launch runs out
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ENG_IDLE;
      job_op <= OP_NONE;
      base <= '0;
      walk <= '0;
      walk_last <= '0;
      timer <= 32'h0000_0000;
    end else begin
      if (timer != 32'h0000_0000 && state != ENG_IDLE) begin
        timer <= timer - 32'h0000_0001;
      end
      case (state)
        ENG_IDLE: begin
          if (launch) begin
            job_op <= opcode;
            walk <= '0;
            if (opcode == OP_PAGE_WRITE) begin
              base <= {cmd_addr[ADDR_BITS-1:8], 8'h00};
              walk_last <= ADDR_BITS'(PAGE_BYTES - 1);
              timer <= 32'(PROGRAM_WAIT);
              state <= ENG_DRAIN;
            end else if (opcode == OP_LARGE_CLEAR) begin
              base <= cmd_addr & ~ADDR_BITS'(BLOCK_BYTES - 1);
              walk_last <= ADDR_BITS'(BLOCK_BYTES - 1);
              timer <= 32'(ERASE_WAIT);
              state <= ENG_WORK;
            end else if (is_erase(opcode)) begin
              base <= cmd_addr & ~ADDR_BITS'(SECTOR_BYTES - 1);
              walk_last <= ADDR_BITS'(SECTOR_BYTES - 1);
              timer <= 32'(ERASE_WAIT);
              state <= ENG_WORK;
            end else begin
              walk_last <= '0;
              timer <= 32'(STATUS_WAIT);
              state <= ENG_WORK;
            end
          end
        end
        ENG_DRAIN: begin
          if (!fifo_out_valid) begin
            state <= ENG_WORK;
          end
        end
        ENG_WORK: begin
          walk <= walk + 1'b1;
          if (walk == walk_last) begin
            state <= ENG_HOLD;
          end
        end
        ENG_HOLD: begin
          if (job_done) begin
            state <= ENG_IDLE;
          end
        end
        default: state <= ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (state == ENG_WORK) begin
      if (job_op == OP_PAGE_WRITE) begin
        if (page_mask[walk[7:0]]) begin
          mem[wr_addr] <= mem[wr_addr] & page_buf[walk[7:0]];
        end
      end else if (is_erase(job_op)) begin
        mem[wr_addr] <= ERASED_BYTE;
      end
    end
  end

  // status register and permit latch
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      operation_in_progress_flag <= 1'b0;
      write_permit_latch <= 1'b0;
      {protect_range_bit_2, protect_range_bit_1, protect_range_bit_0} <= PROTECT_RESET;
      status_lock_bit <= 1'b0;
    end else begin
      if (launch) begin
        operation_in_progress_flag <= 1'b1;
      end else if (job_done) begin
        operation_in_progress_flag <= 1'b0;
      end
      if (job_done) begin
        write_permit_latch <= 1'b0;
      end else if (frame_end && opcode == OP_PERMIT_SET) begin
        write_permit_latch <= 1'b1;
      end else if (frame_end && opcode == OP_PERMIT_CLEAR) begin
        write_permit_latch <= 1'b0;
      end
      if (launch && opcode == OP_STATUS_UPDATE) begin
        {protect_range_bit_2, protect_range_bit_1, protect_range_bit_0} <=
          stat_data[ST_PROTECT_LO+2:ST_PROTECT_LO];
        status_lock_bit <= stat_data[ST_LOCK];
      end
    end
  end

endmodule // serial_flash_core

`default_nettype wire

// >>> test/serial_flash_core_sva.sv
// checker: port-level timing of the flash command core
// assumes one core clock domain with an asynchronous reset
`default_nettype none
module flash_checker #(
  parameter int PROGRAM_WAIT = 5000,
  parameter int ERASE_WAIT = 5000,
  parameter int STATUS_WAIT = 5000
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial link
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic bidir_serial_line_in,
  input wire logic bidir_serial_line_out,
  input wire logic bidir_serial_line_oe_n,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  // status bits
  input wire logic operation_in_progress_flag,
  input wire logic write_permit_latch,
  input wire logic protect_range_bit_2,
  input wire logic protect_range_bit_1,
  input wire logic protect_range_bit_0,
  input wire logic status_lock_bit,
  input wire logic fifo_overrun
);
  localparam int PE_MIN = PROGRAM_WAIT < ERASE_WAIT ? PROGRAM_WAIT : ERASE_WAIT;
  localparam int MIN_WAIT = PE_MIN < STATUS_WAIT ? PE_MIN : STATUS_WAIT;
  int busy_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // long busy times cannot be unrolled, so they are counted here
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) busy_cnt <= 0;
    else if (operation_in_progress_flag) busy_cnt <= busy_cnt + 1;
    else busy_cnt <= 0;
  end
  oe_release_a: assert property (
      chip_select_n [*4] |-> serial_out_oe_n && bidir_serial_line_oe_n)
    else $error("outputs driven while deselected");
  dual_pair_a: assert property (!bidir_serial_line_oe_n |-> !serial_out_oe_n)
    else $error("bidir line driven without serial out");
  so_launch_a: assert property ($changed(serial_out) && !serial_out_oe_n |-> !serial_clk)
    else $error("serial out changed while serial clock high");
  busy_launch_a: assert property (
      $rose(operation_in_progress_flag) |-> chip_select_n)
    else $error("busy rose while selected");
  permit_clear_a: assert property (
      $fell(operation_in_progress_flag) |-> $fell(write_permit_latch))
    else $error("permit latch not cleared with busy");
  permit_set_a: assert property (
      $rose(write_permit_latch) |-> chip_select_n && !operation_in_progress_flag)
    else $error("permit latch set while busy or selected");
  protect_load_a: assert property (
      $changed({status_lock_bit, protect_range_bit_2, protect_range_bit_1, protect_range_bit_0})
      |-> chip_select_n ##[0:2] operation_in_progress_flag)
    else $error("status bits changed outside a status update");
  busy_length_a: assert property (
      $fell(operation_in_progress_flag) |-> busy_cnt >= MIN_WAIT - 2)
    else $error("busy ended too early");
endmodule // flash_checker
bind serial_flash_core flash_checker #(.PROGRAM_WAIT(PROGRAM_WAIT), .ERASE_WAIT(ERASE_WAIT),
  .STATUS_WAIT(STATUS_WAIT)) chk (.*);
`default_nettype wire

// >>> test/spi_host_model.sv
// host model: drives serial clock, select and data, captures read data
// assumes mode 0 framing paced by the core clock, four core cycles a half bit
`default_nettype none
module spi_host (
  // core clock
  input wire logic clock,
  // link to the device
  output logic serial_clk,
  output logic chip_select_n,
  output logic mosi,
  output logic mosi_en,
  input wire logic so_line,
  input wire logic bidir_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
    mosi_en = 1'b1;
  end
  // 80 ns bits keep even plain reads well under their clock limit
  task automatic frame(input logic [7:0] tx [8], input int ntx, input int nrx,
                       input logic dual, output logic [7:0] rx [4]);
    int b;
    int i;
    bit two;
    @(posedge clock);
    chip_select_n <= 1'b0;
    for (b = 0; b < ntx + nrx; b++) begin
      two = dual && b >= ntx;
      for (i = 0; i < 8; i += two ? 2 : 1) begin
        mosi_en <= !two;
        if (b < ntx) mosi <= tx[b][7 - i];
        repeat (4) @(posedge clock);
        serial_clk <= 1'b1;
        repeat (4) @(posedge clock);
        if (b >= ntx) rx[b - ntx][7 - i] = so_line;
        if (two) rx[b - ntx][6 - i] = bidir_line;
        serial_clk <= 1'b0;
      end
    end
    repeat (4) @(posedge clock);
    chip_select_n <= 1'b1;
    mosi_en <= 1'b1;
    repeat (6) @(posedge clock);
  endtask
endmodule // spi_host
`default_nettype wire

// >>> test/testbench.sv
// testbench: drives the flash core through the host model, checks read-back
// assumes small density (16 address bits, 32 KByte blocks) and short busy times
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT = 5000;
  typedef struct packed {logic [7:0] op; logic [23:0] adr; logic [15:0] exp;} row_type;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic serial_clk, chip_select_n, mosi, mosi_en;
  logic bidir_out, bidir_oe_n, serial_out, so_oe_n;
  logic busy, permit, bp2, bp1, bp0, lock, overrun;
  // released lines show the inverse of their last value
  wire logic bidir_line = !bidir_oe_n ? bidir_out : (mosi_en ? mosi : !mosi);
  wire logic so_line = !so_oe_n ? serial_out : !serial_out;
  wire logic [7:0] st_pins = {lock, 2'b00, bp2, bp1, bp0, permit, busy};
  logic [7:0] tx [8];
  logic [7:0] rx [4];
  int mismatches = 0;
  int tests_run = 0;
  row_type rows [8] = '{
    '{8'h03, 24'h00_00fe, 16'ha53c},
    '{8'h0b, 24'h00_0000, 16'h0fff},
    '{8'h3b, 24'h00_00fe, 16'ha53c},
    '{8'h03, 24'hab_0000, 16'h0fff},
    '{8'h0b, 24'h00_ffff, 16'hff0f},
    '{8'h03, 24'h00_0010, 16'hffff},
    '{8'h03, 24'h00_4000, 16'hffff},
    '{8'h3b, 24'h00_efff, 16'hffff}};
  always #5 clock = ~clock;
  spi_host host (.clock(clock), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .mosi(mosi), .mosi_en(mosi_en), .so_line(so_line), .bidir_line(bidir_line));
  serial_flash_core #(.ADDR_BITS(16), .BLOCK_BYTES(32768), .PROGRAM_WAIT(WAIT),
    .ERASE_WAIT(WAIT), .STATUS_WAIT(WAIT)) dut (.clock(clock), .sys_rst(sys_rst),
    .serial_clk(serial_clk), .chip_select_n(chip_select_n), .bidir_serial_line_in(bidir_line),
    .bidir_serial_line_out(bidir_out), .bidir_serial_line_oe_n(bidir_oe_n),
    .serial_out(serial_out), .serial_out_oe_n(so_oe_n), .operation_in_progress_flag(busy),
    .write_permit_latch(permit), .protect_range_bit_2(bp2), .protect_range_bit_1(bp1),
    .protect_range_bit_0(bp0), .status_lock_bit(lock), .fifo_overrun(overrun));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    tests_run++;
    if (got !== want) begin
      mismatches++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic go(input logic [7:0] op, input logic [23:0] adr, input int ntx, input int nrx,
                    input logic dual = 1'b0);
    tx[0] = op;
    {tx[1], tx[2], tx[3]} = adr;
    host.frame(tx, ntx, nrx, dual, rx);
  endtask
  task automatic write_permit_set_cmd();
    go(8'h06, 24'h00_0000, 1, 0);
  endtask
  // polls the status byte, so busy is seen on the wire as well as the pin
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400; n++) begin
      go(8'h05, 24'h00_0000, 1, 1);
      if (rx[0][0] === 1'b0) return;
    end
    mismatches++;
    $display("BAD %0t busy never cleared", $time);
    wrap_up();
  endtask
  initial begin
    int k;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    check(st_pins, 8'h00, "status pins after reset");
    check({6'h00, so_oe_n, bidir_oe_n}, 8'h03, "outputs after reset");
    write_permit_set_cmd();
    check(st_pins, 8'h02, "latch set");
    go(8'h04, 24'h00_0000, 1, 0);
    check(st_pins, 8'h00, "latch cleared by host");
    write_permit_set_cmd();
    go(8'hd8, 24'h00_0000, 4, 0);
    wait_idle();
    check(st_pins, 8'h00, "latch after block clear");
    write_permit_set_cmd();
    go(8'hd7, 24'h00_f123, 4, 0);
    wait_idle();
    write_permit_set_cmd();
    go(8'h20, 24'h00_e000, 4, 0);
    wait_idle();
    write_permit_set_cmd();
    {tx[4], tx[5], tx[6]} = 24'ha5_3c0f;
    go(8'h02, 24'h00_00fe, 7, 0);
    wait_idle();
    check({7'h00, overrun}, 8'h00, "fifo overrun");
    tx[4] = 8'h00;
    go(8'h02, 24'h00_0010, 5, 0);
    check(st_pins, 8'h00, "program without latch");
    for (k = 0; k < 8; k++) begin
      tx[4] = 8'h00;
      go(rows[k].op, rows[k].adr, rows[k].op == 8'h03 ? 4 : 5, 2, rows[k].op == 8'h3b);
      check(rx[0], rows[k].exp[15:8], "first read byte");
      check(rx[1], rows[k].exp[7:0], "second read byte");
    end
    write_permit_set_cmd();
    tx[4] = 8'h0f;
    go(8'h02, 24'h00_00fe, 5, 0);
    wait_idle();
    go(8'h03, 24'h00_00fe, 4, 1);
    check(rx[0], 8'h05, "reprogrammed byte");
    write_permit_set_cmd();
    go(8'h01, 24'h84_0000, 2, 0);
    check(st_pins, 8'h87, "pins during update");
    go(8'h04, 24'h00_0000, 1, 0);
    go(8'h05, 24'h00_0000, 1, 1);
    check(rx[0], 8'h87, "status byte while busy");
    wait_idle();
    check(st_pins, 8'h84, "pins after update");
    write_permit_set_cmd();
    tx[4] = 8'h00;
    go(8'h02, 24'h00_ff00, 5, 0);
    wait_idle();
    go(8'h03, 24'h00_ff00, 4, 1);
    check(rx[0], 8'hff, "guarded page");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
